// [rtl/pcpm_pkg.sv]
// Constants for the third general-purpose port with peripheral pin sharing.
// Assumes a 32-bit APB bus and a single 40 MHz system clock.
package pcpm_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int APB_AW = 12;  // Address width
  localparam int APB_DW = 32;  // Data width
  localparam int PORT_W = 8;   // Pins on the port
  localparam int STRB_W = 4;   // Byte lanes

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [APB_AW-1:0] OFF_LEVELS = 12'h000;  // Pin levels / latch write
  localparam logic [APB_AW-1:0] OFF_LATCH  = 12'h004;  // Output latch
  localparam logic [APB_AW-1:0] OFF_DIR    = 12'h008;  // Direction, 1 = input
  localparam logic [APB_AW-1:0] OFF_CFG    = 12'h00C;  // Peripheral sharing

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;  // Latch cleared
  localparam logic [PORT_W-1:0] RST_DIR   = 8'hFF;  // All pins inputs
  localparam logic [PORT_W-1:0] RST_CFG   = 8'h01;  // Unit two on pin one

  // ----------------------------------------
  // Peripheral sharing field positions
  // ----------------------------------------
  localparam int CFG_CMP2_SEL = 0;  // Unit two uses pin one
  localparam int CFG_OSC_EN   = 1;  // Timer oscillator on
  localparam int CFG_CMP2_EN  = 2;  // Unit two enabled
  localparam int CFG_CMP1_EN  = 3;  // Unit one enabled
  localparam int CFG_PWMA_EN  = 4;  // PWM channel A enabled
  localparam int CFG_SHUT_TRI = 5;  // Tri-state channel A on shutdown
  localparam int CFG_SPI_EN   = 6;  // Serial unit clock enabled
  localparam int CFG_EXT_CNT  = 7;  // Timers count external clock

  // ----------------------------------------
  // Shared pin positions
  // ----------------------------------------
  localparam int PIN_ZERO  = 0;  // Oscillator output / counter clock
  localparam int PIN_ONE   = 1;  // Oscillator input / unit two
  localparam int PIN_TWO   = 2;  // Unit one / PWM channel A
  localparam int PIN_THREE = 3;  // Serial clock
  localparam int PIN_FREE  = 4;  // First pin with no shared function

endpackage

// [rtl/pcpm_byte_reg.sv]
// One software-written byte register with a byte-lane write enable.
// Assumes the caller qualifies the write with a completed bus access.
module pcpm_byte_reg #(
  parameter logic [pcpm_pkg::PORT_W-1:0] RESET_VAL = 8'h00
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        wrEn,
  input  wire logic [pcpm_pkg::PORT_W-1:0] wrData,
  output logic      [pcpm_pkg::PORT_W-1:0] value_q
);
  import pcpm_pkg::*;

  // Store on write, constant on reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      value_q <= RESET_VAL;
    end else if (wrEn) begin
      value_q <= wrData;
    end
  end
endmodule // pcpm_byte_reg

// [rtl/pcpm_pin_cell.sv]
// Registered pin driver: output level and output enable for one pin.
// Assumes the caller has already resolved direction and overrides.
module pcpm_pin_cell (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic driveD,
  input  wire logic enableD,
  output logic      pinOut_q,
  output logic      pinOe_q
);
  // Pin released (input) during reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinOut_q <= 1'b0;
      pinOe_q  <= 1'b0;
    end else begin
      pinOut_q <= driveD;
      pinOe_q  <= enableD;
    end
  end
endmodule // pcpm_pin_cell

// [rtl/pcpm_port_c.sv]
// Eight-pin bidirectional port with latch, direction and peripheral sharing.
// Assumes an APB master on mclk and pin inputs synchronous to mclk.
// The board resolves each pin wire from pinOut and pinOe.
//
// The implementer's own choices: the address map and register access over APB.

// Notes on behaviour
// - Eight pins, each with own direction
// - Direction one releases pin as input
// - Direction zero drives latch value
// - Latch register reads back latch contents
// - Reset makes every pin digital input
// - Direction read returns stored bits always
// - Enabled peripherals may override direction
// - Unit two on pin one when selected
// - Timer oscillator disables pins zero, one
// - Unit two drives or captures pin one
// - Unit one drives or captures pin two
// - PWM channel A, tri-state on shutdown
// - Serial clock drives or reads pin three
module pcpm_port_c (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pcpm_pkg::APB_AW-1:0] paddr,
  input  wire logic [pcpm_pkg::APB_DW-1:0] pwdata,
  input  wire logic [pcpm_pkg::STRB_W-1:0] pstrb,
  output logic      [pcpm_pkg::APB_DW-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [pcpm_pkg::PORT_W-1:0] pinIn,
  output logic      [pcpm_pkg::PORT_W-1:0] pinOut,
  output logic      [pcpm_pkg::PORT_W-1:0] pinOe,
  input  wire logic                        compareUnitTwoOut,
  input  wire logic                        compareUnitOneOut,
  input  wire logic                        pwmChanA,
  input  wire logic                        pwmShutdown,
  input  wire logic                        spiClkOut,
  output logic                             compareUnitTwoCapture,
  output logic                             compareUnitOneCapture,
  output logic                             spiClkIn,
  output logic                             timerCounterClkIn
);
  import pcpm_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Word match on a register offset
  function automatic logic regHit(input logic [APB_AW-1:0] addr,
                                  input logic [APB_AW-1:0] off);
    regHit = (addr == off);
  endfunction

  logic                  hitLevels;  // Pin levels register
  logic                  hitLatch;   // Output latch register
  logic                  hitDir;     // Direction register
  logic                  hitCfg;     // Sharing register
  logic                  hitAny;     // Any mapped register
  logic                  setupRd;    // Setup phase of a read
  logic                  accessWr;   // Completing write
  logic                  lane0;      // Low byte lane written
  logic [PORT_W-1:0]     wrByte;     // Low byte of write data

  assign hitLevels = regHit(paddr, OFF_LEVELS);
  assign hitLatch  = regHit(paddr, OFF_LATCH);
  assign hitDir    = regHit(paddr, OFF_DIR);
  assign hitCfg    = regHit(paddr, OFF_CFG);
  assign hitAny    = hitLevels | hitLatch | hitDir | hitCfg;
  assign setupRd   = psel & ~penable & ~pwrite;
  assign accessWr  = psel & penable & pready & pwrite;
  assign lane0     = pstrb[0];
  assign wrByte    = pwdata[PORT_W-1:0];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [PORT_W-1:0] latch_q;  // Output latch
  logic [PORT_W-1:0] dir_q;    // Direction, 1 = input
  logic [PORT_W-1:0] cfg_q;    // Peripheral sharing
  logic              latchWe;  // Latch write strobe
  logic              dirWe;    // Direction write strobe
  logic              cfgWe;    // Sharing write strobe

  // Latch takes writes through either address
  assign latchWe = accessWr & lane0 & (hitLatch | hitLevels);
  assign dirWe   = accessWr & lane0 & hitDir;
  assign cfgWe   = accessWr & lane0 & hitCfg;

  // Output latch
  pcpm_byte_reg #(.RESET_VAL(RST_LATCH)) uLatch (
    .mclk    (mclk),
    .rst     (rst),
    .wrEn    (latchWe),
    .wrData  (wrByte),
    .value_q (latch_q)
  );

  // Direction bits, all inputs out of reset
  pcpm_byte_reg #(.RESET_VAL(RST_DIR)) uDir (
    .mclk    (mclk),
    .rst     (rst),
    .wrEn    (dirWe),
    .wrData  (wrByte),
    .value_q (dir_q)
  );

  // Peripheral sharing, unit two defaults to pin one
  pcpm_byte_reg #(.RESET_VAL(RST_CFG)) uCfg (
    .mclk    (mclk),
    .rst     (rst),
    .wrEn    (cfgWe),
    .wrData  (wrByte),
    .value_q (cfg_q)
  );

  // ----------------------------------------
  // Peripheral override terms
  // ----------------------------------------
  logic oscOn;     // Timer oscillator owns pins zero and one
  logic cmp2On;    // Unit two mapped here and enabled
  logic cmp1On;    // Unit one enabled
  logic pwmOn;     // PWM channel A enabled
  logic pwmOff;    // Channel A tri-stated by shutdown
  logic spiOn;     // Serial clock enabled
  logic extCount;  // Timers count pin zero

  assign oscOn    = cfg_q[CFG_OSC_EN];
  assign cmp2On   = cfg_q[CFG_CMP2_SEL] & cfg_q[CFG_CMP2_EN] & ~oscOn;
  assign cmp1On   = cfg_q[CFG_CMP1_EN];
  assign pwmOn    = cfg_q[CFG_PWMA_EN];
  assign pwmOff   = pwmOn & pwmShutdown & cfg_q[CFG_SHUT_TRI];
  assign spiOn    = cfg_q[CFG_SPI_EN];
  assign extCount = cfg_q[CFG_EXT_CNT];

  // Per-pin override flag, forced enable and forced level
  logic [PORT_W-1:0] ovrEn;   // Override active
  logic [PORT_W-1:0] ovrOe;   // Forced output enable
  logic [PORT_W-1:0] ovrOut;  // Forced output level
  logic [PORT_W-1:0] oeD;     // Resolved output enable
  logic [PORT_W-1:0] outD;    // Resolved output level

  // Pin zero: oscillator output, digital I/O off
  assign ovrEn[PIN_ZERO]  = oscOn;
  assign ovrOe[PIN_ZERO]  = 1'b0;
  assign ovrOut[PIN_ZERO] = 1'b0;

  // Pin one: oscillator input, else unit two output
  assign ovrEn[PIN_ONE]  = cfg_q[CFG_OSC_EN] | (cmp2On & ~dir_q[PIN_ONE]);
  assign ovrOe[PIN_ONE]  = ~oscOn;
  assign ovrOut[PIN_ONE] = compareUnitTwoOut & ~oscOn;

  // Pin two: channel A forces output, else unit one
  assign ovrEn[PIN_TWO]  = pwmOn | (cmp1On & ~dir_q[PIN_TWO]);
  assign ovrOe[PIN_TWO]  = ~pwmOff;
  assign ovrOut[PIN_TWO] = pwmOn ? pwmChanA : compareUnitOneOut;

  // Pin three: serial clock output
  assign ovrEn[PIN_THREE]  = spiOn & ~dir_q[PIN_THREE];
  assign ovrOe[PIN_THREE]  = 1'b1;
  assign ovrOut[PIN_THREE] = spiClkOut;

  // Upper pins carry no shared function
  assign ovrEn[PORT_W-1:PIN_FREE]  = '0;
  assign ovrOe[PORT_W-1:PIN_FREE]  = '0;
  assign ovrOut[PORT_W-1:PIN_FREE] = '0;

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : gPin
      // Override wins, else direction selects latch drive
      assign oeD[gi]  = ovrEn[gi] ? ovrOe[gi] : ~dir_q[gi];
      assign outD[gi] = ovrEn[gi] ? ovrOut[gi] : latch_q[gi];

      // Registered driver per pin
      pcpm_pin_cell uCell (
        .mclk     (mclk),
        .rst      (rst),
        .driveD   (outD[gi]),
        .enableD  (oeD[gi] & ~rst),
        .pinOut_q (pinOut[gi]),
        .pinOe_q  (pinOe[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Peripheral inputs
  // ----------------------------------------
  logic [PORT_W-1:0] levels;  // Pin levels seen by software
  logic              cap2D;   // Unit two capture level
  logic              cap1D;   // Unit one capture level
  logic              sckD;    // Serial clock input level
  logic              tckD;    // Timer counter clock level

  // Oscillator pins read back as zero
  assign levels = pinIn & ~{{(PORT_W-PIN_FREE){1'b0}}, 2'b00, oscOn, oscOn};
  assign cap2D  = cmp2On & dir_q[PIN_ONE] & pinIn[PIN_ONE];
  assign cap1D  = cmp1On & dir_q[PIN_TWO] & pinIn[PIN_TWO];
  assign sckD   = spiOn & dir_q[PIN_THREE] & pinIn[PIN_THREE];
  assign tckD   = extCount & ~oscOn & dir_q[PIN_ZERO] & pinIn[PIN_ZERO];

  // Registered feeds to the peripherals
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compareUnitTwoCapture <= 1'b0;
      compareUnitOneCapture <= 1'b0;
      spiClkIn              <= 1'b0;
      timerCounterClkIn     <= 1'b0;
    end else begin
      compareUnitTwoCapture <= cap2D;
      compareUnitOneCapture <= cap1D;
      spiClkIn              <= sckD;
      timerCounterClkIn     <= tckD;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  logic [PORT_W-1:0] rdByte;  // Selected read byte

  // Read select; latch and direction read stored bits
  assign rdByte = hitLevels ? levels :
                  hitLatch  ? latch_q :
                  hitDir    ? dir_q :
                  hitCfg    ? cfg_q : '0;

  // Ready one cycle after setup, zero wait states
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hitAny;
    end
  end

  // Read data captured in setup, upper bits zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (setupRd) begin
      prdata <= {{(APB_DW-PORT_W){1'b0}}, rdByte};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Read setup on a given register
  sequence rdSetupAt(logic [APB_AW-1:0] off);
    psel && !penable && !pwrite && paddr == off;
  endsequence

  // Access phase answering at once
  sequence accessDone;
    psel && penable && pready && !pslverr;
  endsequence

  // Write completing on a given register
  sequence wrDoneAt(logic [APB_AW-1:0] off);
    psel && penable && pready && pwrite && pstrb[0] && paddr == off;
  endsequence

  // Released pin on plain direction input
  chk_dir_input_tristate: assert property (
    dir_q[PIN_FREE] |=> !pinOe[PIN_FREE])
    else $error("input pin still driven");

  // Output pin drives latch value
  chk_dir_output_drive: assert property (
    !dir_q[PORT_W-1] |=> pinOe[PORT_W-1] && pinOut[PORT_W-1] == $past(latch_q[PORT_W-1]))
    else $error("output pin not driving latch");

  // Latch read returns stored latch
  chk_latch_readback: assert property (
    rdSetupAt(OFF_LATCH) |=> accessDone ##0 prdata[PORT_W-1:0] == latch_q)
    else $error("latch read mismatch");

  // First edge after reset leaves all pins released
  chk_reset_inputs: assert property (
    $past(rst) |-> pinOe == '0 && dir_q == RST_DIR)
    else $error("pins not inputs after reset");

  // Direction read ignores overrides
  chk_dir_readback: assert property (
    rdSetupAt(OFF_DIR) |=> accessDone ##0 prdata[PORT_W-1:0] == dir_q)
    else $error("direction read mismatch");

  // Oscillator releases pins zero and one
  chk_osc_release: assert property (
    oscOn |=> !pinOe[PIN_ZERO] && !pinOe[PIN_ONE])
    else $error("oscillator pins driven");

  // Unit two output wins on pin one
  chk_unit_two_drive: assert property (
    cmp2On && !dir_q[PIN_ONE] |=>
      pinOe[PIN_ONE] && pinOut[PIN_ONE] == $past(compareUnitTwoOut))
    else $error("unit two not driving pin one");

  // Alternate mapping leaves pin one to the latch
  chk_unit_two_alt: assert property (
    !cfg_q[CFG_CMP2_SEL] && !oscOn && !dir_q[PIN_ONE] |=>
      pinOe[PIN_ONE] && pinOut[PIN_ONE] == $past(latch_q[PIN_ONE]))
    else $error("pin one not left to latch");

  // Unit two capture follows pin one
  chk_unit_two_capture: assert property (
    cmp2On && dir_q[PIN_ONE] |=> compareUnitTwoCapture == $past(pinIn[PIN_ONE]))
    else $error("unit two capture wrong");

  // Unit one output wins on pin two
  chk_unit_one_drive: assert property (
    cmp1On && !pwmOn && !dir_q[PIN_TWO] |=>
      pinOe[PIN_TWO] && pinOut[PIN_TWO] == $past(compareUnitOneOut))
    else $error("unit one not driving pin two");

  // Channel A drives pin two unless shut down
  chk_pwm_drive: assert property (
    pwmOn && !pwmOff |=> pinOe[PIN_TWO] && pinOut[PIN_TWO] == $past(pwmChanA))
    else $error("channel A not driving pin two");

  // Shutdown tri-states channel A
  chk_pwm_shutdown: assert property (
    pwmOff |=> !pinOe[PIN_TWO])
    else $error("channel A driven during shutdown");

  // Serial clock input follows pin three
  chk_spi_clock_in: assert property (
    spiOn && dir_q[PIN_THREE] |=> spiClkIn == $past(pinIn[PIN_THREE]))
    else $error("serial clock input wrong");

  // Levels write lands in latch
  chk_levels_write: assert property (
    wrDoneAt(OFF_LEVELS) |=> latch_q == $past(pwdata[PORT_W-1:0]))
    else $error("levels write lost");

  // Counter clock follows pin zero when selected
  chk_counter_clock: assert property (
    extCount && !oscOn && dir_q[PIN_ZERO] |=> timerCounterClkIn == $past(pinIn[PIN_ZERO]))
    else $error("counter clock wrong");

endmodule // pcpm_port_c

// [bench/pcpm_board_model.sv]
// Board circuitry on the eight port pins: a driver per pin plus pull-ups.
// Assumes the bench changes boardEn and boardVal just after clock edges.
module pcpm_board_model (
  input  wire logic [pcpm_pkg::PORT_W-1:0] pinOut,   // Device drive level
  input  wire logic [pcpm_pkg::PORT_W-1:0] pinOe,    // Device drive enable
  input  wire logic [pcpm_pkg::PORT_W-1:0] boardEn,  // Board drives pin
  input  wire logic [pcpm_pkg::PORT_W-1:0] boardVal, // Board drive level
  output logic      [pcpm_pkg::PORT_W-1:0] pinIn     // Resolved wire level
);
  import pcpm_pkg::*;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // Device first, then board; a released pin floats up
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : (boardEn[i] ? boardVal[i] : 1'b1);
    end
  end
endmodule // pcpm_board_model

// [bench/pcpm_port_c_tb_top.sv]
// Self-checking bench for the shared-pin port, APB master and board.
// Assumes the port answers APB with no wait states and registered pins.
module pcpm_port_c_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pcpm_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic              mclk, rst, psel, penable, pwrite;  // Clock, reset, APB
  logic [APB_AW-1:0] paddr;                             // APB address
  logic [APB_DW-1:0] pwdata, prdata, rdat;              // APB data
  logic [STRB_W-1:0] pstrb;                             // Byte lanes
  logic              pready, pslverr, rerr;             // APB answer
  logic [PORT_W-1:0] pinIn, pinOut, pinOe;              // Pin wires
  logic [PORT_W-1:0] boardEn, boardVal;                 // Board drive
  logic              cmp2Out, cmp1Out, pwmA, pwmShut, spiOut;  // Peripheral outs
  logic              cmp2Cap, cmp1Cap, spiIn, tmrClk;   // Peripheral ins
  int                numErrors, checkCount, cycleCount; // Bookkeeping

  pcpm_port_c pcpm_port_c_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .compareUnitTwoOut(cmp2Out), .compareUnitOneOut(cmp1Out),
    .pwmChanA(pwmA), .pwmShutdown(pwmShut), .spiClkOut(spiOut),
    .compareUnitTwoCapture(cmp2Cap), .compareUnitOneCapture(cmp1Cap),
    .spiClkIn(spiIn), .timerCounterClkIn(tmrClk));

  pcpm_board_model pcpm_board_model_inst (
    .pinOut(pinOut), .pinOe(pinOe), .boardEn(boardEn), .boardVal(boardVal),
    .pinIn(pinIn));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chkWord(input string what, input logic [31:0] exp, got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready, then one idle edge
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                     input logic [31:0] d, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Wait as long as it takes; only the bench timeout ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Write, then let the pins pick up the new register
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
    cyc(1);
  endtask

  task automatic rdChk(input string what, input logic [APB_AW-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chkWord(what, e, rdat);
  endtask

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testReset;
    rdChk("dir", OFF_DIR, 32'hFF);
    rdChk("latch", OFF_LATCH, 32'h0);
    rdChk("cfg", OFF_CFG, 32'h01);
    chkWord("oe", 32'h0, pinOe);
    apb(1'b0, 12'h010, 32'h0, rdat, rerr);
    chkBit("unmapped err", 1'b1, rerr);
    chkWord("unmapped data", 32'h0, rdat);
    $display("test reset done");
  endtask

  task automatic testLatchDir;
    boardEn <= 8'h0F;
    boardVal <= 8'h03;
    wr(OFF_LATCH, 32'hA5);
    wr(OFF_DIR, 32'h0F);
    chkWord("oe", 32'hF0, pinOe);
    chkWord("out", 32'hA, pinOut[7:4]);
    rdChk("latch", OFF_LATCH, 32'hA5);
    rdChk("levels", OFF_LEVELS, 32'hA3);
    wr(OFF_LEVELS, 32'h3C);
    rdChk("latch via levels", OFF_LATCH, 32'h3C);
    chkWord("out2", 32'h3, pinOut[7:4]);
    apb(1'b1, 12'h010, 32'h55, rdat, rerr);
    chkBit("unmapped wr err", 1'b1, rerr);
    pstrb <= 4'h0;
    wr(OFF_LATCH, 32'h00);
    pstrb <= 4'hF;
    rdChk("latch kept", OFF_LATCH, 32'h3C);
    $display("test latch and direction done");
  endtask

  task automatic testOverride;
    boardEn <= 8'h00;
    wr(OFF_LATCH, 32'h0);
    wr(OFF_DIR, 32'h0);
    wr(OFF_CFG, 32'h03);
    chkWord("osc oe", 32'hFC, pinOe);
    rdChk("dir kept", OFF_DIR, 32'h0);
    rdChk("osc masked", OFF_LEVELS, 32'h0);
    cmp2Out <= 1'b1;
    wr(OFF_CFG, 32'h07);
    chkBit("osc over u2", 1'b0, pinOe[1]);
    wr(OFF_CFG, 32'h05);
    chkBit("u2 out", 1'b1, pinOut[1]);
    wr(OFF_CFG, 32'h04);
    chkBit("u2 alt", 1'b0, pinOut[1]);
    cmp1Out <= 1'b1;
    wr(OFF_CFG, 32'h08);
    chkBit("u1 out", 1'b1, pinOut[2]);
    cmp1Out <= 1'b0;
    pwmA <= 1'b1;
    pwmShut <= 1'b1;
    wr(OFF_DIR, 32'h04);
    wr(OFF_CFG, 32'h10);
    chkBit("pwm oe", 1'b1, pinOe[2]);
    chkBit("pwm out", 1'b1, pinOut[2]);
    wr(OFF_CFG, 32'h30);
    chkBit("pwm tri", 1'b0, pinOe[2]);
    pwmShut <= 1'b0;
    cyc(2);
    chkBit("pwm back", 1'b1, pinOe[2]);
    spiOut <= 1'b1;
    wr(OFF_DIR, 32'h0);
    wr(OFF_CFG, 32'h40);
    chkBit("spi out", 1'b1, pinOut[3]);
    $display("test override done");
  endtask

  // Reset in mid-run puts every pin back to input
  task automatic testMidReset;
    rst <= 1'b1;
    cyc(2);
    chkWord("oe in reset", 32'h0, pinOe);
    rst <= 1'b0;
    cyc(1);
    chkWord("oe after reset", 32'h0, pinOe);
    rdChk("dir after reset", OFF_DIR, 32'hFF);
    rdChk("cfg after reset", OFF_CFG, 32'h01);
    $display("test mid-run reset done");
  endtask

  task automatic testCapture;
    boardEn <= 8'hFF;
    wr(OFF_DIR, 32'hFF);
    wr(OFF_CFG, 32'hCD);
    for (int v = 0; v < 2; v++) begin
      boardVal <= v[0] ? 8'hFF : 8'h00;
      cyc(3);
      chkBit("u2 cap", v[0], cmp2Cap);
      chkBit("u1 cap", v[0], cmp1Cap);
      chkBit("spi in", v[0], spiIn);
      chkBit("tmr clk", v[0], tmrClk);
    end
    wr(OFF_CFG, 32'h00);
    cyc(2);
    chkBit("u2 off", 1'b0, cmp2Cap);
    chkBit("tmr off", 1'b0, tmrClk);
    $display("test capture done");
  endtask

  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {boardEn, boardVal} = '0;
    {cmp2Out, cmp1Out, pwmA, pwmShut, spiOut} = '0;
    numErrors = 0;
    checkCount = 0;
    rst = 1'b1;
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    testReset();
    testLatchDir();
    testOverride();
    testMidReset();
    testCapture();
    printVerdict();
  end

  // Cut a hang short
  initial begin
    cycleCount = 0;
    forever begin
      @(posedge mclk);
      cycleCount++;
      if (cycleCount == 5000) begin
        numErrors++;
        printVerdict();
      end
    end
  end
endmodule // pcpm_port_c_tb_top
